// file: pkg/eeu_regs.vh
// Constants for the exception entry unit
`ifndef EEU_REGS_VH
`define EEU_REGS_VH
// Cause codes
`define EEU_CODE_INT 5'h00
`define EEU_CODE_ADDR_ERR_LOAD_CODE 5'h04
`define EEU_CODE_ADDR_ERR_STORE_CODE 5'h05
`define EEU_CODE_IBE 5'h06
`define EEU_CODE_DBE 5'h07
`define EEU_CODE_BP 5'h09
`define EEU_CODE_CPU 5'h0b
// Access size codes
`define EEU_SZ_HALF 2'h1
`define EEU_SZ_WORD 2'h2
// Register indices on the plain port
`define EEU_REG_STATUS 4'h0
`define EEU_REG_CAUSE 4'h1
`define EEU_REG_EPC 4'h2
`define EEU_REG_BADVA 4'h3
// Status layout
`define EEU_ST_IEC 0
`define EEU_ST_KUC 1
`define EEU_ST_IEP 2
`define EEU_ST_KUP 3
`define EEU_ST_IEO 4
`define EEU_ST_KUO 5
`define EEU_ST_IM_LO 8
`define EEU_ST_IM_HI 15
`define EEU_ST_CU_LO 28
`define EEU_ST_CU_HI 31
// Cause layout
`define EEU_CA_CODE_LO 2
`define EEU_CA_CODE_HI 6
`define EEU_CA_SW_LO 8
`define EEU_CA_SW_HI 9
`define EEU_CA_IP_LO 10
`define EEU_CA_IP_HI 15
`define EEU_CA_CE_LO 28
`define EEU_CA_CE_HI 29
`define EEU_CA_BD 31
// Reset values and vector
`define EEU_STATUS_RST 32'h0000_0000
`define EEU_VECTOR 32'h8000_0080
`define EEU_KSEG_BIT 31
`endif

// file: verilog/eeu_exception_entry.v
// Exception entry unit: detection, cause, return pc, status stack, vector
`timescale 1ns/100ps
`include "eeu_regs.vh"
//
// Function
// - Misaligned word or half access gives address error
// - User access to kernel half gives error
// - Load/fetch or store address error code
// - Return pc; branch pc and flag in delay
// - Shift mode/enable stack, clear current pair
// - Address error captures faulting virtual address
// - Redirect fetch to general exception vector
// - Vector fixed at kernel general exception address 8000_0080
// - Break instruction takes breakpoint exception
// - Break spare field is ignored
// - Bus error input on reads traps
// - Fetch or data bus error code
// - Unusable coprocessor traps; kernel may use system
// - Record code and coprocessor number
// - At most one coprocessor reported
// - Synchronous exceptions ignore enables and masks
// - Eight sources, masked, gated by enable
// - Interrupt code; cause shows all pending
// - Software pending bits writable, zero withdraws
module eeu_exception_entry #(
  parameter HW_IRQS = 6
) (
  input wire clk,
  input wire arst_n,
  // Instruction stage view
  input wire instr_valid,
  input wire [31:0] instr_pc,
  input wire [31:0] instr_word,
  input wire in_delay_slot,
  input wire [31:0] branch_pc,
  input wire is_break,
  input wire is_cop,
  input wire [1:0] cop_num,
  // Memory reference of the instruction
  input wire fetch_ref,
  input wire mem_load,
  input wire mem_store,
  input wire [1:0] mem_size,
  input wire [31:0] mem_addr,
  input wire bus_read_active,
  input wire bus_error_in,
  input wire bus_err_fetch,
  input wire [HW_IRQS-1:0] hw_irq_in,
  // Register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Pipeline control
  output reg exc_taken,
  output reg [31:0] fetch_redirect_pc,
  output reg squash_writes,
  output reg kernel_user_now,
  output reg irq_enable_now
);

  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  localparam [1:0] SZ_WORD = `EEU_SZ_WORD;
  localparam [1:0] SZ_HALF = `EEU_SZ_HALF;
  // Two software sources sit below the hardware ones
  localparam NSRC = HW_IRQS + 2;

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [31:0] status_q;
  reg [31:0] status_d;
  reg [4:0] cause_code_field_q;
  reg [4:0] cause_code_d;
  reg branch_delay_flag_q;
  reg branch_delay_d;
  reg [1:0] cop_err_q;
  reg [1:0] cop_err_d;
  reg [1:0] soft_irq_pending_field_q;
  reg [1:0] soft_irq_d;
  reg [HW_IRQS-1:0] hw_irq_pending_field_q;
  reg [31:0] exception_return_pc_q;
  reg [31:0] epc_d;
  reg [31:0] faulting_vaddr_reg_q;
  reg [31:0] badva_d;
  reg [31:0] cause_bits;
  reg [31:0] rdata_d;

  // ----------------------------------------
  // Reference decode
  // ----------------------------------------
  wire ref_data = mem_load | mem_store;
  wire ref_any = fetch_ref | ref_data;
  // A fetch is always a full word, whatever the size input says
  wire [1:0] acc_size = fetch_ref ? SZ_WORD : mem_size;
  wire [31:0] ref_addr = fetch_ref ? instr_pc : mem_addr;
  // Fetch side wins if both are flagged, so a fetch never reports a store
  wire store_ref = mem_store & ~fetch_ref;

  // ----------------------------------------
  // Address error
  // ----------------------------------------
  wire mis_word = (acc_size == SZ_WORD) && (ref_addr[1:0] != 2'h0);
  wire mis_half = (acc_size == SZ_HALF) && ref_addr[0];
  wire in_user = status_q[`EEU_ST_KUC];
  wire user_kseg = in_user && ref_addr[`EEU_KSEG_BIT];
  wire addr_fault = mis_word | mis_half | user_kseg;
  wire addr_err = instr_valid && ref_any && addr_fault;

  // ----------------------------------------
  // Bus error, break, coprocessor
  // ----------------------------------------
  // Write faults arrive later as interrupts, so only reads trap here
  wire bus_err = instr_valid && bus_read_active && bus_error_in;
  // Break decoded by opcode only; bits 25..6 never looked at
  wire brk = instr_valid && is_break;
  wire [3:0] cu_bits = status_q[`EEU_ST_CU_HI:`EEU_ST_CU_LO];
  wire sys_unit = (cop_num == 2'h0);
  // System unit usable whenever in kernel mode
  wire cop_ok = cu_bits[cop_num] || (sys_unit && !in_user);
  wire cop_unus = instr_valid && is_cop && !cop_ok;

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  wire [NSRC-1:0] pend = {hw_irq_pending_field_q, soft_irq_pending_field_q};
  wire [NSRC-1:0] im = status_q[`EEU_ST_IM_LO+NSRC-1:`EEU_ST_IM_LO];
  wire [NSRC-1:0] irq_hit;
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_src
      // Each source gated by its own mask bit
      assign irq_hit[gi] = pend[gi] & im[gi];
    end
  endgenerate
  // Global enable gates all eight at once
  wire irq = instr_valid && status_q[`EEU_ST_IEC] && (|irq_hit);

  // ----------------------------------------
  // Entry decision
  // ----------------------------------------
  // Sync causes never gated by enable or mask
  wire sync_take = addr_err | bus_err | brk | cop_unus;
  wire take = sync_take | irq;
  // Fixed priority so exactly one cause is recorded
  wire sel_addr = addr_err;
  wire sel_bus = bus_err & ~addr_err;
  wire sel_cop = cop_unus & ~addr_err & ~bus_err;
  wire sel_brk = brk & ~addr_err & ~bus_err & ~cop_unus;
  wire sel_irq = irq & ~sync_take;

  // ----------------------------------------
  // Cause code next value
  // ----------------------------------------
  always @* begin
    cause_code_d = cause_code_field_q;
    if (sel_addr) begin
      cause_code_d = store_ref ? `EEU_CODE_ADDR_ERR_STORE_CODE : `EEU_CODE_ADDR_ERR_LOAD_CODE;
    end
    if (sel_bus) begin
      cause_code_d = bus_err_fetch ? `EEU_CODE_IBE : `EEU_CODE_DBE;
    end
    if (sel_cop) begin
      cause_code_d = `EEU_CODE_CPU;
    end
    if (sel_brk) begin
      cause_code_d = `EEU_CODE_BP;
    end
    if (sel_irq) begin
      cause_code_d = `EEU_CODE_INT;
    end
  end

  // ----------------------------------------
  // Coprocessor number next value
  // ----------------------------------------
  // Kept from the last unusable trap; other causes leave it alone
  always @* begin
    cop_err_d = cop_err_q;
    if (sel_cop) begin
      cop_err_d = cop_num;
    end
  end

  // ----------------------------------------
  // Return pc and delay flag next value
  // ----------------------------------------
  always @* begin
    epc_d = exception_return_pc_q;
    branch_delay_d = branch_delay_flag_q;
    if (take) begin
      epc_d = in_delay_slot ? branch_pc : instr_pc;
      branch_delay_d = in_delay_slot;
    end
  end

  // ----------------------------------------
  // Faulting address next value
  // ----------------------------------------
  always @* begin
    badva_d = faulting_vaddr_reg_q;
    if (sel_addr) begin
      badva_d = ref_addr;
    end
  end

  // ----------------------------------------
  // Status next value
  // ----------------------------------------
  always @* begin
    status_d = status_q;
    if (reg_wr && reg_addr == `EEU_REG_STATUS) begin
      status_d = reg_wdata;
    end
    if (take) begin
      // Stack push: old<=prev, prev<=now, now cleared
      status_d[`EEU_ST_KUO] = status_q[`EEU_ST_KUP];
      status_d[`EEU_ST_IEO] = status_q[`EEU_ST_IEP];
      status_d[`EEU_ST_KUP] = status_q[`EEU_ST_KUC];
      status_d[`EEU_ST_IEP] = status_q[`EEU_ST_IEC];
      status_d[`EEU_ST_KUC] = 1'b0;
      status_d[`EEU_ST_IEC] = 1'b0;
    end
  end

  // ----------------------------------------
  // Software pending next value
  // ----------------------------------------
  always @* begin
    soft_irq_d = soft_irq_pending_field_q;
    if (reg_wr && reg_addr == `EEU_REG_CAUSE) begin
      soft_irq_d = reg_wdata[`EEU_CA_SW_HI:`EEU_CA_SW_LO];
    end
  end

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= `EEU_STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // ----------------------------------------
  // Cause fields
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cause_code_field_q <= 5'h00;
      branch_delay_flag_q <= 1'b0;
      cop_err_q <= 2'h0;
    end else begin
      cause_code_field_q <= cause_code_d;
      branch_delay_flag_q <= branch_delay_d;
      cop_err_q <= cop_err_d;
    end
  end

  // ----------------------------------------
  // Pending interrupts
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_irq_pending_field_q <= 2'h0;
    end else begin
      soft_irq_pending_field_q <= soft_irq_d;
    end
  end

  // One cycle of latency traded for a clean registered view of the pins
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hw_irq_pending_field_q <= {HW_IRQS{1'b0}};
    end else begin
      // Levels only, no internal clear
      hw_irq_pending_field_q <= hw_irq_in;
    end
  end

  // ----------------------------------------
  // Return pc and faulting address
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exception_return_pc_q <= 32'h0000_0000;
    end else begin
      exception_return_pc_q <= epc_d;
    end
  end

  // Not touched by other causes, so it keeps the last bad address
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      faulting_vaddr_reg_q <= 32'h0000_0000;
    end else begin
      faulting_vaddr_reg_q <= badva_d;
    end
  end

  // ----------------------------------------
  // Read view
  // ----------------------------------------
  always @* begin
    cause_bits = 32'h0000_0000;
    cause_bits[`EEU_CA_BD] = branch_delay_flag_q;
    cause_bits[`EEU_CA_CE_HI:`EEU_CA_CE_LO] = cop_err_q;
    cause_bits[`EEU_CA_IP_LO+HW_IRQS-1:`EEU_CA_IP_LO] = hw_irq_pending_field_q;
    cause_bits[`EEU_CA_SW_HI:`EEU_CA_SW_LO] = soft_irq_pending_field_q;
    cause_bits[`EEU_CA_CODE_HI:`EEU_CA_CODE_LO] = cause_code_field_q;
  end

  // Data stand one cycle only, zero otherwise
  always @* begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `EEU_REG_STATUS: rdata_d = status_q;
        `EEU_REG_CAUSE: rdata_d = cause_bits;
        `EEU_REG_EPC: rdata_d = exception_return_pc_q;
        `EEU_REG_BADVA: rdata_d = faulting_vaddr_reg_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // ----------------------------------------
  // Pipeline control outputs
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exc_taken <= 1'b0;
      squash_writes <= 1'b0;
    end else begin
      exc_taken <= take;
      // Held through the entry cycle so late stages also drop
      squash_writes <= take;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_redirect_pc <= 32'h0000_0000;
    end else begin
      fetch_redirect_pc <= `EEU_VECTOR;
    end
  end

  // Mirrors of the current pair, in step with the status register
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      kernel_user_now <= 1'b0;
      irq_enable_now <= 1'b0;
    end else begin
      kernel_user_now <= status_d[`EEU_ST_KUC];
      irq_enable_now <= status_d[`EEU_ST_IEC];
    end
  end

endmodule

// file: bench/eeu_asserts.sv
// Port checker for the exception entry unit
`timescale 1ns/100ps
module eeu_asserts (
  input wire clk,
  input wire arst_n,
  input wire instr_valid,
  input wire is_break,
  input wire mem_load,
  input wire mem_store,
  input wire [1:0] mem_size,
  input wire [31:0] mem_addr,
  input wire exc_taken,
  input wire squash_writes,
  input wire [31:0] fetch_redirect_pc,
  input wire kernel_user_now,
  input wire irq_enable_now
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire dref = instr_valid & (mem_load | mem_store);
  sequence s_brk;
    instr_valid && is_break;
  endsequence
  a_word_align: assert property (dref && mem_size == 2'h2 && mem_addr[1:0] != 2'h0 |=> exc_taken)
    else $error("word misalign missed");
  a_half_align: assert property (dref && mem_size == 2'h1 && mem_addr[0] |=> exc_taken)
    else $error("half misalign missed");
  a_user_kseg: assert property (dref && kernel_user_now && mem_addr[31] |=> exc_taken)
    else $error("user kernel access missed");
  a_break_trap: assert property (s_brk |=> exc_taken) else $error("break missed");
  a_squash_pair: assert property (exc_taken |-> squash_writes) else $error("no squash");
  a_no_cause: assert property (!instr_valid |=> !squash_writes) else $error("stray squash");
  a_vector_fix: assert property (exc_taken |-> fetch_redirect_pc == 32'h8000_0080)
    else $error("bad vector");
  a_stack_clear: assert property (exc_taken |-> !kernel_user_now && !irq_enable_now)
    else $error("current pair kept");
endmodule
bind eeu_exception_entry eeu_asserts eeu_asserts_i (.clk, .arst_n, .instr_valid, .is_break, .mem_load, .mem_store,
  .mem_size, .mem_addr, .exc_taken, .squash_writes, .fetch_redirect_pc, .kernel_user_now, .irq_enable_now);

// file: bench/eeu_far_side.sv
// Bus error and interrupt source model
`timescale 1ns/100ps
module eeu_far_side (
  input wire clk,
  input wire arst_n,
  input wire bus_read_active,
  input wire err_req,
  input wire [5:0] irq_set,
  input wire [5:0] irq_clr,
  output wire bus_error_in,
  output reg [5:0] hw_irq_in
);
  // Posted write faults never use this pin
  assign bus_error_in = bus_read_active & err_req;
  // Level held until the source clears it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      hw_irq_in <= 6'h00;
    else
      hw_irq_in <= (hw_irq_in | irq_set) & ~irq_clr;
  end
endmodule

// file: bench/eeu_tb_top.sv
// Self-checking bench for the exception entry unit
`timescale 1ns/100ps
module eeu_tb_top;
  logic clk, arst_n, iv, ds, brk, cop, fr, ld, stq, bra, erq, bef, ber, wr, rd, exc, sq, ku, ie;
  logic [31:0] pc, iw, bpc, ma, wd, rdat, vec, a, w;
  logic [1:0] cn, sz, sw, ce;
  logic [3:0] ra;
  logic [5:0] iset, iclr, hw, hv;
  int n_errors, samples_checked;
  logic [4:0] cd[7] = '{5'h04, 5'h05, 5'h04, 5'h07, 5'h0b, 5'h09, 5'h06};
  // Kind strobes: load, store, read, error, fetch error, fetch, cop, break
  logic [7:0] kt[7] = '{8'h80, 8'h40, 8'h80, 8'hb0, 8'h02, 8'h01, 8'h3c};
  eeu_exception_entry eeu_exception_entry_i (.clk, .arst_n, .instr_valid(iv), .instr_pc(pc), .instr_word(iw),
    .in_delay_slot(ds), .branch_pc(bpc), .is_break(brk), .is_cop(cop), .cop_num(cn), .fetch_ref(fr), .mem_load(ld),
    .mem_store(stq), .mem_size(sz), .mem_addr(ma), .bus_read_active(bra), .bus_error_in(ber), .bus_err_fetch(bef),
    .hw_irq_in(hw), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .exc_taken(exc),
    .fetch_redirect_pc(vec), .squash_writes(sq), .kernel_user_now(ku), .irq_enable_now(ie));
  eeu_far_side eeu_far_side_i (.clk, .arst_n, .bus_read_active(bra), .err_req(erq), .irq_set(iset),
    .irq_clr(iclr), .bus_error_in(ber), .hw_irq_in(hw));
  function automatic logic [31:0] cause(logic b, logic [5:0] h, logic [1:0] s, logic [4:0] c);
    return {b, 1'b0, ce, 12'h0, h, s, 1'b0, c, 2'h0};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      n_errors++;
    end
  endtask
  task acc(input logic we, input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk);
    ra <= ad;
    wd <= d;
    wr <= we;
    rd <= !we;
    @(posedge clk);
    {wr, rd} <= 2'h0;
    #1 if (!we) chk(rdat, d);
  endtask
  task ins(input logic e);
    iv <= 1'b1;
    @(posedge clk);
    {iv, ld, stq, bra, erq, bef, fr, cop, brk} <= 9'h0;
    #1 chk({30'h0, exc, sq}, {30'h0, e, e});
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ------
  // Tests
  // ------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #50000;
    n_errors++;
    test_done;
  end
  initial begin
    {iv, ds, brk, cop, fr, ld, stq, bra, erq, bef, wr, rd, arst_n} = 13'h0;
    {pc, iw, bpc, ma, wd, cn, sz, ce, ra, iset, iclr} = 182'h0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    void'($urandom(12));
    acc(1'b0, 4'h0, 32'h0);
    for (int k = 0; k < 7; k++) begin
      w = $urandom & 32'h3f;
      a = $urandom & 32'h7fff_fffc;
      if (k == 0) a[1:0] = 2'($urandom_range(3, 1));
      if (k == 1) a[0] = 1'b1;
      if (k == 2) {a[31], w[1]} = 2'h3;
      acc(1'b1, 4'h0, w);
      @(posedge clk);
      pc <= $urandom & 32'h7fff_fffc;
      bpc <= $urandom & 32'hffff_fffc;
      ds <= 1'($urandom);
      iw <= $urandom;
      ma <= a;
      sz <= k == 1 ? 2'h1 : 2'h2;
      cn <= 2'($urandom_range(3, 1));
      {ld, stq, bra, erq, bef, fr, cop, brk} <= kt[k];
      ins(1'b1);
      if (k == 4) ce = cn;
      acc(1'b0, 4'h1, cause(ds, 6'h0, 2'h0, cd[k]));
      acc(1'b0, 4'h2, ds ? bpc : pc);
      if (k < 3) acc(1'b0, 4'h3, a);
      acc(1'b0, 4'h0, {26'h0, w[3:0], 2'h0});
      chk(vec, 32'h8000_0080);
      chk({30'h0, ku, ie}, 32'h0);
      $display("test %0d done", k);
    end
    hv = 6'($urandom_range(63, 1));
    sw = 2'($urandom_range(3, 1));
    @(posedge clk);
    ds <= 1'b0;
    iset <= hv;
    @(posedge clk);
    iset <= 6'h0;
    acc(1'b1, 4'h1, {22'h0, sw, 8'h0});
    acc(1'b1, 4'h0, 32'h0000_ff00);
    @(posedge clk);
    ins(1'b0);
    acc(1'b1, 4'h0, 32'h0000_0001);
    @(posedge clk);
    ins(1'b0);
    acc(1'b1, 4'h0, 32'h0000_ff01);
    @(posedge clk);
    chk({30'h0, ku, ie}, 32'h1);
    ins(1'b1);
    acc(1'b0, 4'h1, cause(1'b0, hv, sw, 5'h00));
    acc(1'b0, 4'h0, 32'h0000_ff04);
    @(posedge clk);
    iclr <= 6'h3f;
    acc(1'b1, 4'h1, 32'h0);
    iclr <= 6'h0;
    acc(1'b0, 4'h1, cause(1'b0, 6'h0, 2'h0, 5'h00));
    acc(1'b1, 4'hf, $urandom);
    acc(1'b0, 4'hf, 32'h0);
    $display("irq test done");
    test_done;
  end
endmodule
